//--- sensor_adc_battery_monitor_regs.vh
// register offsets, field positions, reset values and timing counts
// for the converter, temperature sensor and battery monitor readout.
// assumes a 50 MHz system clock and a byte-wide register space on SPI.
//
// What this block does
// - two-bit gain code picks 22..88/13, or 33..132/13 with low ref bit set
// - selected differential range 16.7..4.2 percent supply maps onto code 255
// - gain follows reference choice so range and result stay unchanged
// - four-bit offset: top set adds low*0.12%, clear subtracts (8-low)*0.12%, or nothing when low is 0
// - converter is unipolar, codes non-negative; offset shifts negatives up
// - temperature sensor powers up when selected as input or on test bus
// - shift on, range codes give four documented temperature spans and steps
// - shift off with range 10 gives 0..341 K test mode; shift resets to 1
// - with trim enabled the four-bit trim adjusts the sensor bandgap
// - supply digitised to 5 bits, 50 mV steps from 1.7 V, 31 above 3.2 V
// - battery monitor runs only when enabled; level readable any time
// - enabled monitor powers every 1 s for about 250 us per measurement
// - monitor enabled in sleep starts the RC oscillator automatically
// - level below threshold with interrupt enabled drives irq_n_out low
// - interrupt raised only after four consecutive readings below threshold
// - start bit begins one conversion, reads busy, self-clears when done
`ifndef SENSOR_ADC_BATTERY_MONITOR_REGS_VH
`define SENSOR_ADC_BATTERY_MONITOR_REGS_VH

`define ADDR_INT_STATUS1   7'h03
`define ADDR_INT_STATUS2   7'h04
`define ADDR_INT_ENABLE2   7'h06
`define ADDR_OP_MODE       7'h07
`define ADDR_ADC_CONFIG    7'h0f
`define ADDR_AMP_OFFSET    7'h10
`define ADDR_ADC_VALUE     7'h11
`define ADDR_TS_CONTROL    7'h12
`define ADDR_TV_OFFSET     7'h13
`define ADDR_BAT_THRESHOLD 7'h1a
`define ADDR_BAT_LEVEL     7'h1b

`define BIT_LOWBAT         2
`define BIT_MON_ENABLE     6
`define BIT_ADC_START      7
`define BIT_TS_SHIFT       5
`define BIT_TS_TRIM        4

`define RST_ADC_CONFIG     8'h00
`define RST_TS_CONTROL     8'h20
`define RST_TV_OFFSET      8'h00
`define RST_BAT_THRESHOLD  5'h14

`define GAIN_BASE_LOWREF   8'h16
`define GAIN_BASE_HIGHREF  8'h21
`define BELOW_COUNT_FIRE   3'h4

`define CLK_MHZ            50
`define CONV_TIME_US       350
`define CONV_CYCLES        (`CONV_TIME_US * `CLK_MHZ)
`define BAT_PERIOD_MS      1000
`define BAT_PERIOD_CYCLES  (`BAT_PERIOD_MS * 1000 * `CLK_MHZ)
`define BAT_ON_TIME_US     250
`define BAT_ON_CYCLES      (`BAT_ON_TIME_US * `CLK_MHZ)

`endif

//--- sensor_adc_battery_monitor.v
// readout and control logic for the 8-bit converter, temperature sensor
// and battery monitor, with an SPI register slave in front.
// assumes SCLK at most clk_sys/8 and analog codes stable at sample time.
`timescale 1ns/1ns
`include "sensor_adc_battery_monitor_regs.vh"

module sensor_adc_battery_monitor #(
   parameter CONV_CYCLES   = `CONV_CYCLES,
   parameter PERIOD_CYCLES = `BAT_PERIOD_CYCLES,
   parameter ON_CYCLES     = `BAT_ON_CYCLES
) (
   input  wire       clk_sys,
   input  wire       sys_rst,
   input  wire       spi_sel_n,
   input  wire       spi_sclk,
   input  wire       spi_sdi,
   output reg        spi_sdo,
   output reg        spi_sdo_oe,
   input  wire       sleep_mode,
   input  wire       atest_temp_sel,
   input  wire [7:0] adc_sample,
   input  wire [4:0] bat_code,
   output reg        irq_n_out,
   output reg        conv_active,
   output reg  [2:0] conv_input_sel,
   output reg  [1:0] conv_ref_sel,
   output reg  [7:0] amp_gain_x13,
   output reg  [3:0] amp_offset_steps,
   output reg        ts_enable,
   output reg  [1:0] ts_range,
   output reg        ts_offset_shift,
   output reg  [3:0] bandgap_trim,
   output reg        bat_power,
   output reg        rc_osc_enable
);

   // reset image of the converter configuration register
   localparam [7:0] ADC_CFG_RST = `RST_ADC_CONFIG;

   // gain numerator over 13: base times (code + 1); the larger base on the
   // third-supply reference keeps the input range the same on both
   function [7:0] gain_of;
      input [1:0] code;
      input       ref_low;
      reg   [7:0] base;
      begin
         base = ref_low ? `GAIN_BASE_HIGHREF : `GAIN_BASE_LOWREF;
         gain_of = base * ({6'h00, code} + 8'h01);
      end
   endfunction

   // signed offset in 0.12 percent steps, two's complement towards the
   // analog side; code 0xxx with low bits zero means no offset at all
   function [3:0] offset_of;
      input [3:0] code;
      begin
         if (code[3])
            offset_of = {1'b0, code[2:0]};
         else if (code[2:0] == 3'h0)
            offset_of = 4'h0;
         else
            offset_of = {1'b1, code[2:0]};
      end
   endfunction

   // pin synchronisers; sclk keeps a third flop for its edge detector
   // and select resets high so no false frame follows reset
   reg [2:0] sclk_sync;
   reg [1:0] sel_sync;
   reg [1:0] sdi_sync;
   reg [7:0] sample_s1;
   reg [7:0] sample_s2;
   reg [4:0] bat_s1;
   reg [4:0] bat_s2;

   // register file
   // reserved bits are not stored, so they read back as zero
   reg        adc_busy;
   reg [2:0]  adc_sel;
   reg [1:0]  adc_ref;
   reg [1:0]  adc_gain;
   reg [3:0]  amp_offset;
   reg [7:0]  adc_value;
   reg [7:0]  ts_control;
   reg [7:0]  tv_offset;
   reg [4:0]  bat_threshold;
   reg [4:0]  bat_level;
   reg        mon_enable;
   reg        lowbat_irq_en;
   reg        lowbat_flag;

   // spi shifter
   // one shared byte shifter: write data in, read data out; the address shifts into spi_addr
   reg [3:0]  spi_cnt;
   reg        spi_write;
   reg [6:0]  spi_addr;
   reg [7:0]  spi_shift;
   reg        spi_done;

   // timers
   // 32 bits cover the full one-second period at the system clock
   reg [31:0] conv_timer;
   reg [31:0] period_timer;
   reg [2:0]  below_count;

   wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   wire sclk_fall = ~sclk_sync[1] & sclk_sync[2];
   wire selected  = ~sel_sync[1];
   // the read mux decodes at the seventh address edge, when the last
   // address bit is still on the data line and not yet in spi_addr;
   // decoding spi_addr alone would read another register
   wire [6:0] rd_addr = {spi_addr[5:0], sdi_sync[1]};

   reg [7:0] rd_data;
   reg       wr_strobe;
   reg       rd_strobe;
   reg [7:0] wr_data;

   // synchronise the spi pins and analog codes through two flops
   // analog codes may change mid-sample; a settled code is assumed
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sclk_sync <= 3'h0;
         sel_sync  <= 2'h3;
         sdi_sync  <= 2'h0;
         sample_s1 <= 8'h00;
         sample_s2 <= 8'h00;
         bat_s1    <= 5'h00;
         bat_s2    <= 5'h00;
      end else begin
         sclk_sync <= {sclk_sync[1:0], spi_sclk};
         sel_sync  <= {sel_sync[0], spi_sel_n};
         sdi_sync  <= {sdi_sync[0], spi_sdi};
         sample_s1 <= adc_sample;
         sample_s2 <= sample_s1;
         bat_s1    <= bat_code;
         bat_s2    <= bat_s1;
      end
   end

   // read mux, reserved bits read zero; unmapped addresses read zero too,
   // so a host probing the space sees no stale value
   always @* begin
      rd_data = 8'h00;
      case (rd_addr)
         `ADDR_INT_STATUS1:   rd_data = 8'h00;
         `ADDR_INT_STATUS2:   rd_data = {5'h00, lowbat_flag, 2'h0};
         `ADDR_INT_ENABLE2:   rd_data = {5'h00, lowbat_irq_en, 2'h0};
         `ADDR_OP_MODE:       rd_data = {1'b0, mon_enable, 6'h00};
         `ADDR_ADC_CONFIG:
            rd_data = {adc_busy, adc_sel, adc_ref, adc_gain};
         `ADDR_AMP_OFFSET:    rd_data = {4'h0, amp_offset};
         `ADDR_ADC_VALUE:     rd_data = adc_value;
         `ADDR_TS_CONTROL:    rd_data = ts_control;
         `ADDR_TV_OFFSET:     rd_data = tv_offset;
         `ADDR_BAT_THRESHOLD: rd_data = {3'h0, bat_threshold};
         `ADDR_BAT_LEVEL:     rd_data = {3'h0, bat_level};
         default:             rd_data = 8'h00;
      endcase
   end

   // strobes: write at the sixteenth bit, read when the address is in
   // the read load at the last address edge leaves a full half period
   // before the first data bit has to stand on spi_sdo
   always @* begin
      wr_strobe = selected & sclk_rise & spi_write & (spi_cnt == 4'hf)
                  & ~spi_done;
      rd_strobe = selected & sclk_rise & ~spi_write & (spi_cnt == 4'h7)
                  & ~spi_done;
      wr_data   = {spi_shift[6:0], sdi_sync[1]};
   end

   // spi frame: rw bit, 7 address bits, 8 data bits, msb first
   // one register per frame; extra clocks after the data are ignored
   // select high resets the bit count, so a cut frame writes nothing
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         spi_cnt    <= 4'h0;
         spi_write  <= 1'b0;
         spi_addr   <= 7'h00;
         spi_shift  <= 8'h00;
         spi_done   <= 1'b0;
         spi_sdo    <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else if (!selected) begin
         spi_cnt    <= 4'h0;
         spi_done   <= 1'b0;
         spi_sdo    <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else begin
         spi_sdo_oe <= 1'b1;
         if (sclk_rise && !spi_done) begin
            spi_cnt <= spi_cnt + 4'h1;
            if (spi_cnt == 4'h0)
               spi_write <= sdi_sync[1];
            else if (spi_cnt < 4'h8)
               spi_addr <= {spi_addr[5:0], sdi_sync[1]};
            if (spi_cnt == 4'hf)
               spi_done <= 1'b1;
            // on a read the falling edge owns the shifter after the load;
            // shifting here too would drop every other data bit
            if (rd_strobe)
               spi_shift <= rd_data;
            else if (spi_write)
               spi_shift <= wr_data;
         end else if (sclk_fall && !spi_write && spi_cnt >= 4'h8
                      && !spi_done) begin
            // data leaves on the falling edge so the master samples it rising
            spi_sdo   <= spi_shift[7];
            spi_shift <= {spi_shift[6:0], 1'b0};
         end
      end
   end

   // writable registers and the conversion sequencer
   // busy lasts CONV_CYCLES clocks; the code is taken on the last of them
   // through the synchroniser, so it must be settled by then
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         adc_busy      <= ADC_CFG_RST[7];
         adc_sel       <= ADC_CFG_RST[6:4];
         adc_ref       <= ADC_CFG_RST[3:2];
         adc_gain      <= ADC_CFG_RST[1:0];
         amp_offset    <= 4'h0;
         adc_value     <= 8'h00;
         ts_control    <= `RST_TS_CONTROL;
         tv_offset     <= `RST_TV_OFFSET;
         bat_threshold <= `RST_BAT_THRESHOLD;
         mon_enable    <= 1'b0;
         lowbat_irq_en <= 1'b0;
         conv_timer    <= 32'h0;
      end else begin
         if (wr_strobe) begin
            case (spi_addr)
               `ADDR_INT_ENABLE2: lowbat_irq_en <= wr_data[`BIT_LOWBAT];
               `ADDR_OP_MODE:     mon_enable <= wr_data[`BIT_MON_ENABLE];
               `ADDR_ADC_CONFIG: begin
                  adc_sel  <= wr_data[6:4];
                  adc_ref  <= wr_data[3:2];
                  adc_gain <= wr_data[1:0];
               end
               `ADDR_AMP_OFFSET:    amp_offset <= wr_data[3:0];
               `ADDR_TS_CONTROL:    ts_control <= wr_data;
               `ADDR_TV_OFFSET:     tv_offset <= wr_data;
               `ADDR_BAT_THRESHOLD: bat_threshold <= wr_data[4:0];
               default: ;
            endcase
         end
         // a start while busy is ignored; the running conversion finishes
         // so a double start cannot shorten the running conversion
         if (adc_busy) begin
            if (conv_timer >= CONV_CYCLES - 1) begin
               adc_busy   <= 1'b0;
               adc_value  <= sample_s2;
               conv_timer <= 32'h0;
            end else begin
               conv_timer <= conv_timer + 32'h1;
            end
         end else if (wr_strobe && spi_addr == `ADDR_ADC_CONFIG
                      && wr_data[`BIT_ADC_START]) begin
            adc_busy   <= 1'b1;
            conv_timer <= 32'h0;
         end
      end
   end

   // battery monitor: periodic power window, sample at its end
   // the first window after enable is one clock shorter, since the timer
   // starts at zero on the enabling clock; the count saturates at four,
   // so a long low run raises the flag only once
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         period_timer <= 32'h0;
         bat_level    <= 5'h00;
         below_count  <= 3'h0;
         bat_power    <= 1'b0;
      end else if (!mon_enable) begin
         period_timer <= 32'h0;
         below_count  <= 3'h0;
         bat_power    <= 1'b0;
      end else begin
         if (period_timer >= PERIOD_CYCLES - 1)
            period_timer <= 32'h0;
         else
            period_timer <= period_timer + 32'h1;
         bat_power <= (period_timer < ON_CYCLES - 1)
                      || (period_timer >= PERIOD_CYCLES - 1);
         if (period_timer == ON_CYCLES - 1) begin
            bat_level <= bat_s2;
            if (bat_s2 < bat_threshold) begin
               if (below_count != `BELOW_COUNT_FIRE)
                  below_count <= below_count + 3'h1;
            end else begin
               below_count <= 3'h0;
            end
         end
      end
   end

   // low-battery flag: set wins over the clear-on-read of status 2
   // so a reading that lands on the host's read is never lost
   always @(posedge clk_sys) begin
      if (sys_rst)
         lowbat_flag <= 1'b0;
      else if (below_count == `BELOW_COUNT_FIRE - 3'h1 && mon_enable
               && period_timer == ON_CYCLES - 1 && bat_s2 < bat_threshold)
         lowbat_flag <= 1'b1;
      else if (rd_strobe && rd_addr == `ADDR_INT_STATUS2)
         lowbat_flag <= 1'b0;
   end

   // analog control outputs, all registered
   // so the analog side never sees a decode glitch
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_n_out        <= 1'b1;
         conv_active      <= 1'b0;
         conv_input_sel   <= 3'h0;
         conv_ref_sel     <= 2'h0;
         amp_gain_x13     <= 8'h00;
         amp_offset_steps <= 4'h0;
         ts_enable        <= 1'b0;
         ts_range         <= 2'h0;
         ts_offset_shift  <= 1'b1;
         bandgap_trim     <= 4'h0;
         rc_osc_enable    <= 1'b0;
      end else begin
         irq_n_out        <= ~(lowbat_flag & lowbat_irq_en);
         conv_active      <= adc_busy;
         conv_input_sel   <= adc_sel;
         conv_ref_sel     <= adc_ref;
         amp_gain_x13     <= gain_of(adc_gain, adc_ref[0]);
         amp_offset_steps <= offset_of(amp_offset);
         ts_enable        <= (adc_sel == 3'h0) | atest_temp_sel;
         ts_range         <= ts_control[7:6];
         ts_offset_shift  <= ts_control[`BIT_TS_SHIFT];
         bandgap_trim     <= ts_control[`BIT_TS_TRIM] ?
                             ts_control[3:0] : 4'h0;
         rc_osc_enable    <= mon_enable & sleep_mode;
      end
   end

endmodule // sensor_adc_battery_monitor

//--- mcu_model.sv
// spi controller model standing in for the host microcontroller
// assumes clk_sys is the block clock; pins move 2 ns after its edges
`timescale 1ns/1ns
module mcu_model (
   input  wire  clk_sys,
   output logic spi_sel_n,
   output logic spi_sclk,
   output logic spi_sdi,
   input  wire  spi_sdo
);
   // pins idle: deselected, clock standing low
   initial begin
      spi_sel_n = 1'b1;
      spi_sclk  = 1'b0;
      spi_sdi   = 1'b0;
   end

   // every pin change lands the same small delay after an edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   // one frame: write flag, 7 address bits, 8 data bits, msb first;
   // half period of 8 clocks leaves room for the block's synchronisers
   task automatic xfer(input logic wr, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [15:0] w;
      w = {wr, a, d};
      q = 8'h00;
      wait_clk(1);
      spi_sel_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         // on a read the data bits are unused, so they toggle
         spi_sdi = (i < 8 && !wr) ? i[0] : w[i];
         wait_clk(8);
         spi_sclk = 1'b1;
         if (i < 8)
            q[i] = spi_sdo;
         wait_clk(8);
         spi_sclk = 1'b0;
      end
      wait_clk(2);
      spi_sel_n = 1'b1;
      spi_sdi = ~spi_sdi;
      wait_clk(6);
   endtask
endmodule // mcu_model

//--- sensor_adc_battery_monitor_sva.sv
// assertions on the readout block's ports, bound into every instance
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
module adc_bat_checker #(
   parameter CONV_CYCLES = 17500
) (
   input wire       clk_sys,
   input wire       sys_rst,
   input wire       spi_sel_n,
   input wire       spi_sdo_oe,
   input wire       sleep_mode,
   input wire       atest_temp_sel,
   input wire       irq_n_out,
   input wire       conv_active,
   input wire [2:0] conv_input_sel,
   input wire [1:0] conv_ref_sel,
   input wire [7:0] amp_gain_x13,
   input wire [3:0] amp_offset_steps,
   input wire       ts_enable,
   input wire       ts_offset_shift,
   input wire       bat_power,
   input wire       rc_osc_enable
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // length of the running busy stretch, zero while idle
   logic [31:0] run_len;
   always @(posedge clk_sys) begin
      if (sys_rst || !conv_active)
         run_len <= 32'h0;
      else
         run_len <= run_len + 32'h1;
   end

   sequence busy_run;
      conv_active[*8];
   endsequence
   sequence win_on;
      bat_power[*8];
   endsequence

   chk_gain_low: assert property (
      !$past(sys_rst) && !conv_ref_sel[0] |->
      amp_gain_x13 inside {8'h16, 8'h2c, 8'h42, 8'h58})
      else $error("gain off the half-supply set");
   chk_gain_high: assert property (
      !$past(sys_rst) && conv_ref_sel[0] |->
      amp_gain_x13 inside {8'h21, 8'h42, 8'h63, 8'h84})
      else $error("gain off the third-supply set");
   chk_offs_code: assert property (amp_offset_steps != 4'h8)
      else $error("offset of minus eight steps");
   chk_ts_auto: assert property (
      !$past(sys_rst) |-> ts_enable ==
      (conv_input_sel == 3'h0 || $past(atest_temp_sel)))
      else $error("sensor enable not tied to its users");
   chk_rc_sleep: assert property (rc_osc_enable |-> $past(sleep_mode))
      else $error("rc oscillator on outside sleep");
   chk_reset_out: assert property (disable iff (1'b0)
      sys_rst |=> irq_n_out && ts_offset_shift)
      else $error("reset levels wrong");
   chk_win_len: assert property ($rose(bat_power) |-> win_on)
      else $error("measurement window cut short");
   chk_conv_hold: assert property ($rose(conv_active) |-> busy_run)
      else $error("conversion dropped early");
   chk_conv_len: assert property (
      $fell(conv_active) |-> run_len == CONV_CYCLES)
      else $error("conversion length wrong");
   chk_oe_free: assert property (spi_sel_n[*5] |-> !spi_sdo_oe)
      else $error("data out driven while deselected");
endmodule // adc_bat_checker

bind sensor_adc_battery_monitor adc_bat_checker
   #(.CONV_CYCLES(CONV_CYCLES)) chk (.*);

//--- tb.sv
// top bench: resets the block, then runs register, gain, offset,
// temperature and battery scenarios through the spi controller model
// assumes the model and checker files are compiled before it
`timescale 1ns/1ns
module tb;
   localparam int CONV = 600;
   localparam int PER  = 2000;
   localparam int ON   = 10;
   logic       clk_sys, sys_rst, sleep_mode, atest_temp_sel;
   logic [7:0] adc_sample;
   logic [4:0] bat_code;
   wire        spi_sel_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
   wire        irq_n_out, conv_active, ts_enable, ts_offset_shift;
   wire        bat_power, rc_osc_enable;
   wire  [2:0] conv_input_sel;
   wire  [1:0] conv_ref_sel, ts_range;
   wire  [7:0] amp_gain_x13;
   wire  [3:0] amp_offset_steps, bandgap_trim;
   int         n_fail, comparisons, cyc, w;

   // short counts so a battery period and a conversion stay cheap
   sensor_adc_battery_monitor #(.CONV_CYCLES(CONV), .PERIOD_CYCLES(PER),
      .ON_CYCLES(ON)) DUT (.*);
   mcu_model mcu (.*);

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // hang guard well above the roughly 30000 cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         results();
      end
   end

   task automatic results();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] x;
      mcu.xfer(1'b1, a, d, x);
   endtask

   task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] x;
      mcu.xfer(1'b0, a, 8'h00, x);
      check(x, exp);
   endtask

   // high length of the next measurement window, bounded by a period
   task automatic wait_win(output int len);
      int n;
      n = 0;
      len = 0;
      while (!bat_power && n < PER + 20) begin
         mcu.wait_clk(1);
         n++;
      end
      while (bat_power && len < PER) begin
         mcu.wait_clk(1);
         len++;
      end
   endtask

   task automatic t_reset();
      rdc(7'h12, 8'h20);
      rdc(7'h1a, 8'h14);
      rdc(7'h7f, 8'h00);
      wr(7'h13, 8'h5c);
      rdc(7'h13, 8'h5c);
      check(ts_offset_shift, 1'b1);
      check(irq_n_out, 1'b1);
   endtask

   task automatic t_gain();
      for (int r = 0; r < 2; r++) begin
         for (int g = 0; g < 4; g++) begin
            // ref bit set stands for a supply above 2.7 V
            wr(7'h0f, {4'h1, 1'b0, r[0], g[1:0]});
            check(amp_gain_x13, 8'((r ? 33 : 22) * (g + 1)));
         end
      end
      check(ts_enable, 1'b0);
      atest_temp_sel = 1'b1;
      mcu.wait_clk(3);
      check(ts_enable, 1'b1);
      atest_temp_sel = 1'b0;
   endtask

   task automatic t_offs();
      logic [3:0] e;
      for (int c = 0; c < 16; c++) begin
         wr(7'h10, 8'(c));
         // plus low steps, or minus (8 - low) steps, zero for code 0
         e = 4'(c[3] ? (c & 7) : ((c & 7) == 0 ? 0 : (c & 7) - 8));
         check(amp_offset_steps, e);
      end
   endtask

   task automatic t_temp();
      adc_sample = 8'hb4;
      wr(7'h0f, 8'h00);
      check(ts_enable, 1'b1);
      for (int r = 0; r < 4; r++) begin
         wr(7'h12, {r[1:0], 6'h3a});
         check(ts_range, r[1:0]);
      end
      check(bandgap_trim, 4'ha);
      wr(7'h0f, 8'h80);
      rdc(7'h0f, 8'h80);
      mcu.wait_clk(CONV);
      rdc(7'h0f, 8'h00);
      // code 0xb4 reads back unchanged, as 180, from the value register
      rdc(7'h11, 8'hb4);
      // a second code with every bit flipped exercises each input line
      adc_sample = 8'h4b;
      wr(7'h0f, 8'h80);
      mcu.wait_clk(CONV);
      rdc(7'h0f, 8'h00);
      rdc(7'h11, 8'h4b);
      wr(7'h12, 8'h8a);
      check(bandgap_trim, 4'h0);
      check(ts_offset_shift, 1'b0);
   endtask

   task automatic t_bat();
      wr(7'h1a, 8'h10);
      bat_code = 5'h1f;
      sleep_mode = 1'b1;
      wr(7'h06, 8'h04);
      wr(7'h07, 8'h40);
      check(rc_osc_enable, 1'b1);
      wait_win(w);
      check(8'(w), 8'(ON));
      bat_code = 5'h0f;
      rdc(7'h1b, 8'h1f);
      repeat (3) wait_win(w);
      check(irq_n_out, 1'b1);
      wait_win(w);
      mcu.wait_clk(4);
      check(irq_n_out, 1'b0);
      rdc(7'h03, 8'h00);
      rdc(7'h04, 8'h04);
      // a disable must restart the run of low readings
      wr(7'h07, 8'h00);
      rdc(7'h04, 8'h00);
      check(irq_n_out, 1'b1);
      wr(7'h07, 8'h40);
      repeat (2) wait_win(w);
      mcu.wait_clk(4);
      check(irq_n_out, 1'b1);
      wait_win(w);
      mcu.wait_clk(4);
      check(irq_n_out, 1'b0);
      sleep_mode = 1'b0;
      mcu.wait_clk(3);
      check(rc_osc_enable, 1'b0);
   endtask

   initial begin
      sys_rst = 1'b1;
      sleep_mode = 1'b0;
      atest_temp_sel = 1'b0;
      adc_sample = 8'h00;
      bat_code = 5'h00;
      repeat (4) @(posedge clk_sys);
      #2;
      sys_rst = 1'b0;
      mcu.wait_clk(4);
      t_reset();
      t_gain();
      t_offs();
      t_temp();
      t_bat();
      results();
   end
endmodule // tb
